/* tcc_top.sv */
/*
  Holds the top of the triple comparator control block: the Wishbone
  register slave, three channels, pin drive and the interrupt logic.
  Assumes the analog comparators, reference and input switches sit outside,
  and that CMP_RAW are their asynchronous results.
*/
`timescale 1ns/100ps
`include "tcc_defines.svh"
// Function
// - Enable bit runs or stops the comparator.
// - Drive enable puts the result on pin.
// - Invert bit flips result, pin and events.
// - Result bit is one when plus exceeds minus.
// - Selected edge sets event, blocks further triggers.
// - Event and result bits are read only.
// - Status bits 16 to 18 mirror events.
// - Status bits 0 to 2 mirror results.
// - Halt in idle stops all comparators.
// - Status select bit picks external reference.
// - Unimplemented bits read as zero.
// - All implemented bits reset to zero.
// - Edge field picks any, fall, rise, off.
// - Plus select picks reference or pin A.
// - Minus select picks pin B, C, D, gap.

module tcc_top (
  // Clock and reset.
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // Wishbone slave.
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Device state.
  input  wire logic        IDLE,
  // Analog results and switch controls.
  input  wire logic [2:0]  CMP_RAW,
  output logic      [2:0]  CMP_ENABLE,
  output logic      [2:0]  PLUS_SEL,
  output logic      [5:0]  MINUS_SEL,
  output logic             REF_EXTERNAL,
  // Result pins.
  output logic      [2:0]  RESULT_PIN,
  output logic      [2:0]  RESULT_OE,
  // Interrupt.
  output logic             IRQ
);
  import tcc_pkg::*;

  tcc_cfg_t    cfg_q [3];
  logic        halt_q;
  logic        refsel_q;
  logic [2:0]  active_q;
  logic [2:0]  pin_q;
  logic [2:0]  oe_q;
  logic [2:0]  ifl_q;
  logic [2:0]  ifl_d;
  logic [2:0]  ifl_clr;
  logic [2:0]  imask_q;
  logic        irq_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [31:0] stat_w;
  logic [2:0]  res;
  logic [2:0]  evt;
  logic [2:0]  trig;
  logic        req;
  logic        rd_take;
  logic        wr_fire;

  function automatic logic [7:0] ctrl_adr(input int idx);
    return `TCC_ADR_CTRL1 + 8'(`TCC_ADR_STRIDE * idx);
  endfunction : ctrl_adr

  function automatic tcc_cfg_t cfg_write(input tcc_cfg_t c,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    tcc_cfg_t n;
    n = c;
    if (s[1]) begin
      n.on     = d[`TCC_CTL_ON];
      n.drive  = d[`TCC_CTL_DRIVE];
      n.invert = d[`TCC_CTL_INV];
    end
    if (s[0]) begin
      n.edge_sel  = d[`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO];
      n.plus_sel  = d[`TCC_CTL_PLUS];
      n.minus_sel = d[`TCC_CTL_MINUS_HI:`TCC_CTL_MINUS_LO];
    end
    return n;
  endfunction : cfg_write

  function automatic logic [31:0] ctrl_word(input tcc_cfg_t c,
                                            input logic evt_b,
                                            input logic res_b);
    logic [31:0] w;
    w = `TCC_RESET_WORD;
    w[`TCC_CTL_ON]    = c.on;
    w[`TCC_CTL_DRIVE] = c.drive;
    w[`TCC_CTL_INV]   = c.invert;
    w[`TCC_CTL_EVT]   = evt_b;
    w[`TCC_CTL_RES]   = res_b;
    w[`TCC_CTL_EDGE_HI:`TCC_CTL_EDGE_LO]   = c.edge_sel;
    w[`TCC_CTL_PLUS]  = c.plus_sel;
    w[`TCC_CTL_MINUS_HI:`TCC_CTL_MINUS_LO] = c.minus_sel;
    return w;
  endfunction : ctrl_word

  // Bus handshake: read data is caught at the request, writes act with ack.
  assign req     = WB_CYC_I & WB_STB_I;
  assign rd_take = req & ~ack_q & ~WB_WE_I;
  assign wr_fire = req & ack_q & WB_WE_I;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      dat_q <= `TCC_RESET_WORD;
    end else if (rd_take) begin
      dat_q <= rd_d;
    end
  end

  // Shared status word.
  always_comb begin
    stat_w = `TCC_RESET_WORD;
    stat_w[`TCC_ST_EVT_HI:`TCC_ST_EVT_LO] = evt;
    stat_w[`TCC_ST_RES_HI:`TCC_ST_RES_LO] = res;
    stat_w[`TCC_ST_HALT]   = halt_q;
    stat_w[`TCC_ST_REFSEL] = refsel_q;
  end

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    rd_d = `TCC_RESET_WORD;
    if (WB_ADR_I == `TCC_ADR_STATUS) begin
      rd_d = stat_w;
    end
    if (WB_ADR_I == `TCC_ADR_IFLAG) begin
      rd_d[`TCC_IRQ_HI:0] = ifl_q;
    end
    if (WB_ADR_I == `TCC_ADR_IMASK) begin
      rd_d[`TCC_IRQ_HI:0] = imask_q;
    end
    for (int k = 0; k < 3; k++) begin
      if (WB_ADR_I == ctrl_adr(k)) begin
        rd_d = ctrl_word(cfg_q[k], evt[k], res[k]);
      end
    end
  end

  // Shared status settings.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      halt_q   <= 1'b0;
      refsel_q <= 1'b0;
    end else if (wr_fire && WB_ADR_I == `TCC_ADR_STATUS && WB_SEL_I[1]) begin
      halt_q   <= WB_DAT_I[`TCC_ST_HALT];
      refsel_q <= WB_DAT_I[`TCC_ST_REFSEL];
    end
  end

  // Channels with their settings.
  for (genvar i = 0; i < 3; i++) begin : g_unit
    always_ff @(posedge MCLK) begin
      if (!RST_N) begin
        cfg_q[i] <= `TCC_CFG_RESET;
      end else if (wr_fire && WB_ADR_I == ctrl_adr(i)) begin
        cfg_q[i] <= cfg_write(cfg_q[i], WB_DAT_I, WB_SEL_I);
      end
    end

    always_ff @(posedge MCLK) begin
      if (!RST_N) begin
        active_q[i] <= 1'b0;
      end else begin
        active_q[i] <= cfg_q[i].on & ~(halt_q & IDLE);
      end
    end

    always_ff @(posedge MCLK) begin
      if (!RST_N) begin
        pin_q[i] <= 1'b0;
        oe_q[i]  <= 1'b0;
      end else begin
        pin_q[i] <= res[i] & cfg_q[i].drive;
        oe_q[i]  <= cfg_q[i].drive;
      end
    end

    tcc_unit u_unit (
      .clk        (MCLK),
      .rst_n      (RST_N),
      .enable     (cfg_q[i].on),
      .active     (active_q[i]),
      .invert     (cfg_q[i].invert),
      .edge_sel   (cfg_q[i].edge_sel),
      .raw        (CMP_RAW[i]),
      .result     (res[i]),
      .event_flag (evt[i]),
      .trigger    (trig[i])
    );

    assign PLUS_SEL[i]            = cfg_q[i].plus_sel;
    assign MINUS_SEL[2*i+1 -: 2]  = cfg_q[i].minus_sel;
  end

  // Interrupt flags: a trigger wins over a write-one clear in the same cycle.
  always_comb begin
    ifl_clr = `TCC_BITS_RESET;
    if (wr_fire && WB_ADR_I == `TCC_ADR_IFLAG && WB_SEL_I[0]) begin
      ifl_clr = WB_DAT_I[`TCC_IRQ_HI:0];
    end
    ifl_d = (ifl_q & ~ifl_clr) | trig;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ifl_q <= `TCC_BITS_RESET;
    end else begin
      ifl_q <= ifl_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      imask_q <= `TCC_BITS_RESET;
    end else if (wr_fire && WB_ADR_I == `TCC_ADR_IMASK && WB_SEL_I[0]) begin
      imask_q <= WB_DAT_I[`TCC_IRQ_HI:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ifl_q & imask_q);
    end
  end

  assign WB_DAT_O     = dat_q;
  assign WB_ACK_O     = ack_q;
  assign CMP_ENABLE   = active_q;
  assign REF_EXTERNAL = refsel_q;
  assign RESULT_PIN   = pin_q;
  assign RESULT_OE    = oe_q;
  assign IRQ          = irq_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  property p_res_copy;
    ack_q && !WB_WE_I && WB_ADR_I == `TCC_ADR_STATUS
      |-> WB_DAT_O[`TCC_ST_RES_HI:`TCC_ST_RES_LO] == $past(res);
  endproperty
  a_res_copy: assert property (p_res_copy) else $error("status result copy wrong");

  property p_evt_copy;
    ack_q && !WB_WE_I && WB_ADR_I == `TCC_ADR_STATUS
      |-> WB_DAT_O[`TCC_ST_EVT_HI:`TCC_ST_EVT_LO] == $past(evt);
  endproperty
  a_evt_copy: assert property (p_evt_copy) else $error("status event copy wrong");

  property p_ctrl_zero;
    ack_q && !WB_WE_I && WB_ADR_I == `TCC_ADR_CTRL1 |-> WB_DAT_O[31:16] == 16'h0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("upper bits not zero");

  property p_reset;
    $past(!RST_N) |-> cfg_q[0] == `TCC_CFG_RESET && !halt_q && !refsel_q && !IRQ;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value not zero");

  property p_pin_off;
    !RESULT_OE[0] |-> !RESULT_PIN[0];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

  property p_idle_halt;
    halt_q && IDLE ##1 halt_q && IDLE |-> CMP_ENABLE == 3'h0 && trig == 3'h0;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("runs in halted idle");

  property p_irq;
    trig[0] && imask_q[0] ##1 imask_q[0] |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_off_en;
    !cfg_q[1].on |=> !CMP_ENABLE[1];
  endproperty
  a_off_en: assert property (p_off_en) else $error("disabled unit active");

  property p_trig_wins;
    trig[0] |=> ifl_q[0];
  endproperty
  a_trig_wins: assert property (p_trig_wins) else $error("trigger lost to clear");

  property p_evt_block;
    evt[1] |-> !trig[1];
  endproperty
  a_evt_block: assert property (p_evt_block) else $error("trigger while event set");

  property p_stat_zero;
    ack_q && !WB_WE_I && WB_ADR_I == `TCC_ADR_STATUS |-> WB_DAT_O[31:19] == 13'h0000;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status upper bits set");

  property p_oe_follow;
    RESULT_OE[2] == $past(cfg_q[2].drive);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable wrong");

  property p_off_clear;
    !cfg_q[2].on |=> !res[2] && !evt[2];
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("disabled unit shows state");

  property p_halt_hold;
    cfg_q[0].on && !active_q[0] |=> $stable(res[0]);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted result moved");

  c_trig: cover property (trig != 3'h0);
  c_irq: cover property ($rose(IRQ));
  c_stat: cover property (ack_q && !WB_WE_I && WB_ADR_I == `TCC_ADR_STATUS);
  c_idle: cover property (halt_q && IDLE && cfg_q[0].on);

endmodule : tcc_top

/* tcc_defines.svh */
/*
  Holds the register offsets, field positions, codes and reset values of
  the triple comparator control block as macros.
  Assumes nothing of its surroundings; it holds definitions only.
*/
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Register byte offsets.
`define TCC_ADR_STATUS   8'h00
`define TCC_ADR_CTRL1    8'h04
`define TCC_ADR_STRIDE   8'h04
`define TCC_ADR_IFLAG    8'h10
`define TCC_ADR_IMASK    8'h14

// Control register fields.
`define TCC_CTL_ON       15
`define TCC_CTL_DRIVE    14
`define TCC_CTL_INV      13
`define TCC_CTL_EVT      9
`define TCC_CTL_RES      8
`define TCC_CTL_EDGE_HI  7
`define TCC_CTL_EDGE_LO  6
`define TCC_CTL_PLUS     4
`define TCC_CTL_MINUS_HI 1
`define TCC_CTL_MINUS_LO 0

// Status register fields.
`define TCC_ST_EVT_HI    18
`define TCC_ST_EVT_LO    16
`define TCC_ST_HALT      13
`define TCC_ST_REFSEL    8
`define TCC_ST_RES_HI    2
`define TCC_ST_RES_LO    0

// Interrupt flag and mask fields.
`define TCC_IRQ_HI       2

// Edge select codes.
`define TCC_EDGE_ANY     2'h3
`define TCC_EDGE_FALL    2'h2
`define TCC_EDGE_RISE    2'h1
`define TCC_EDGE_OFF     2'h0

// Reset values.
`define TCC_RESET_WORD   32'h0000_0000
`define TCC_CFG_RESET    8'h00
`define TCC_BITS_RESET   3'h0

`endif

/* tcc_pkg.sv */
/*
  Holds the types of the triple comparator control block.
  Assumes no macros of tcc_defines.svh; its widths are written as numbers.
*/
package tcc_pkg;

  typedef logic [1:0] tcc_edge_t;

  typedef struct packed {
    logic       on;
    logic       drive;
    logic       invert;
    tcc_edge_t  edge_sel;
    logic       plus_sel;
    logic [1:0] minus_sel;
  } tcc_cfg_t;

endpackage : tcc_pkg

/* tcc_unit.sv */
/*
  Holds one comparator channel: result synchroniser, polarity, edge
  detection and the sticky event flag.
  Assumes raw is asynchronous to clk and that active already folds in the
  enable bit and the halt in idle.
*/
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_unit (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Settings.
  input  wire logic               enable,
  input  wire logic               active,
  input  wire logic               invert,
  input  wire tcc_pkg::tcc_edge_t edge_sel,
  // Analog result.
  input  wire logic               raw,
  // Status.
  output logic                    result,
  output logic                    event_flag,
  output logic                    trigger
);
  import tcc_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic res_q;
  logic evt_q;
  logic res_d;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  assign res_d = sync2_q ^ invert;
  assign rise  = active & res_d & ~res_q;
  assign fall  = active & ~res_d & res_q;

  always_comb begin
    unique case (edge_sel)
      `TCC_EDGE_ANY:  hit = rise | fall;
      `TCC_EDGE_FALL: hit = fall;
      `TCC_EDGE_RISE: hit = rise;
      `TCC_EDGE_OFF:  hit = 1'b0;
    endcase
  end

  assign trigger = hit & ~evt_q & enable;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_q <= 1'b0;
    end else if (!enable) begin
      res_q <= 1'b0;
    end else if (active) begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_q <= 1'b0;
    end else if (!enable) begin
      evt_q <= 1'b0;
    end else if (trigger) begin
      evt_q <= 1'b1;
    end
  end

  assign result     = res_q;
  assign event_flag = evt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sync_true;
    (enable && active && !invert && raw)[*4] |-> result;
  endproperty
  a_sync_true: assert property (p_sync_true) else $error("result not high");

  property p_sync_inv;
    (enable && active && invert && raw)[*4] |-> !result;
  endproperty
  a_sync_inv: assert property (p_sync_inv) else $error("inverted result high");

  property p_evt_hold;
    event_flag && enable |=> event_flag;
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event flag lost");

  property p_evt_clr;
    !enable |=> !event_flag;
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("event flag kept");

  property p_evt_cause;
    $rose(event_flag) |-> $past(trigger);
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without cause");

  property p_edge_off;
    edge_sel == `TCC_EDGE_OFF |-> !trigger;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("trigger while off");

endmodule : tcc_unit

/* tcc_top_tb.sv */
/*
  Self-checking testbench of the triple comparator control block.
  Assumes tcc_top with its Wishbone slave, 20 MHz MCLK and RST_N.
*/
`timescale 1ns/100ps
`include "tcc_defines.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tcc_top_tb;
  typedef struct {
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } tcc_row_t;

  logic        MCLK     = 1'b0;
  logic        RST_N    = 1'b0;
  logic        WB_CYC_I = 1'b0;
  logic        WB_STB_I = 1'b0;
  logic        WB_WE_I  = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [3:0]  WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0000_0000;
  logic [31:0] WB_DAT_O;
  logic        WB_ACK_O;
  logic        IDLE     = 1'b0;
  logic [2:0]  CMP_RAW  = 3'h0;
  logic [2:0]  CMP_ENABLE;
  logic [2:0]  PLUS_SEL;
  logic [5:0]  MINUS_SEL;
  logic        REF_EXTERNAL;
  logic [2:0]  RESULT_PIN;
  logic [2:0]  RESULT_OE;
  logic        IRQ;
  logic [31:0] rd;
  int          bad_count = 0;
  int          compares  = 0;

  // Ordinary register cases: written word and the word read back.
  tcc_row_t rows [7] = '{
    '{`TCC_ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_2100},
    '{`TCC_ADR_CTRL1,  32'hFFFF_5FFF, 32'h0000_40D3},
    '{8'h08,           32'h0000_20C1, 32'h0000_20C1},
    '{8'h0C,           32'h0000_0012, 32'h0000_0012},
    '{`TCC_ADR_IMASK,  32'hFFFF_FFFF, 32'h0000_0007},
    '{8'h18,           32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h01,           32'hFFFF_FFFF, 32'h0000_0000}
  };

  always #25 MCLK = ~MCLK;

  tcc_top dut_u (
    .MCLK         (MCLK),
    .RST_N        (RST_N),
    .WB_CYC_I     (WB_CYC_I),
    .WB_STB_I     (WB_STB_I),
    .WB_WE_I      (WB_WE_I),
    .WB_ADR_I     (WB_ADR_I),
    .WB_SEL_I     (WB_SEL_I),
    .WB_DAT_I     (WB_DAT_I),
    .WB_DAT_O     (WB_DAT_O),
    .WB_ACK_O     (WB_ACK_O),
    .IDLE         (IDLE),
    .CMP_RAW      (CMP_RAW),
    .CMP_ENABLE   (CMP_ENABLE),
    .PLUS_SEL     (PLUS_SEL),
    .MINUS_SEL    (MINUS_SEL),
    .REF_EXTERNAL (REF_EXTERNAL),
    .RESULT_PIN   (RESULT_PIN),
    .RESULT_OE    (RESULT_OE),
    .IRQ          (IRQ)
  );

  task automatic results;
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Runs one classic Wishbone cycle and waits for ack under a bound.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= dat;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    `CHK(rd, exp)
  endtask : rchk

  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
  endtask : step

  initial begin
    step(2);
    RST_N <= 1'b1;
    step(1);
    `CHK({CMP_ENABLE, RESULT_OE, RESULT_PIN, IRQ}, 10'h000)
    for (int i = 0; i < 4; i++) begin
      rchk(8'(4 * i), 32'h0000_0000);
    end
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wdat);
      rchk(rows[i].adr, rows[i].exp);
    end
    step(2);
    `CHK(PLUS_SEL, 3'h5)
    `CHK(MINUS_SEL, 6'h27)
    `CHK(REF_EXTERNAL, 1'b1)
    `CHK({RESULT_OE, RESULT_PIN}, 6'h08)
    // Unit one: rising edge event, sticky flag and interrupt.
    wb(1'b1, `TCC_ADR_CTRL1, 32'h0000_C040);
    CMP_RAW <= 3'h1;
    step(6);
    `CHK(CMP_ENABLE, 3'h1)
    `CHK({RESULT_PIN, IRQ}, 4'h3)
    rchk(`TCC_ADR_CTRL1, 32'h0000_C340);
    rchk(`TCC_ADR_STATUS, 32'h0001_2101);
    CMP_RAW <= 3'h0;
    step(6);
    rchk(`TCC_ADR_STATUS, 32'h0001_2100);
    wb(1'b1, `TCC_ADR_IFLAG, 32'h0000_0001);
    CMP_RAW <= 3'h1;
    step(6);
    `CHK(IRQ, 1'b0)
    rchk(`TCC_ADR_IFLAG, 32'h0000_0000);
    wb(1'b1, `TCC_ADR_CTRL1, 32'h0000_0000);
    step(2);
    rchk(`TCC_ADR_CTRL1, 32'h0000_0000);
    rchk(`TCC_ADR_STATUS, 32'h0000_2100);
    // Unit two: inverted result, falling edge select.
    wb(1'b1, 8'h08, 32'h0000_A080);
    step(6);
    rchk(`TCC_ADR_STATUS, 32'h0000_2102);
    CMP_RAW <= 3'h3;
    step(6);
    rchk(`TCC_ADR_STATUS, 32'h0002_2100);
    rchk(8'h08, 32'h0000_A280);
    wb(1'b1, `TCC_ADR_IMASK, 32'h0000_0000);
    step(2);
    `CHK(IRQ, 1'b0)
    wb(1'b1, `TCC_ADR_IMASK, 32'h0000_0007);
    step(2);
    `CHK(IRQ, 1'b1)
    wb(1'b1, `TCC_ADR_IFLAG, 32'h0000_0007);
    wb(1'b1, 8'h08, 32'h0000_0000);
    step(2);
    `CHK(IRQ, 1'b0)
    // Unit three: halt in idle, then edge codes off and any.
    wb(1'b1, 8'h0C, 32'h0000_8000);
    IDLE <= 1'b1;
    step(3);
    `CHK(CMP_ENABLE[2], 1'b0)
    IDLE <= 1'b0;
    step(3);
    `CHK(CMP_ENABLE[2], 1'b1)
    CMP_RAW <= 3'h7;
    step(6);
    rchk(`TCC_ADR_STATUS, 32'h0000_2104);
    wb(1'b1, 8'h0C, 32'h0000_80C0);
    CMP_RAW <= 3'h3;
    step(6);
    rchk(`TCC_ADR_STATUS, 32'h0004_2100);
    wb(1'b1, `TCC_ADR_STATUS, 32'h0000_0000);
    IDLE <= 1'b1;
    step(3);
    `CHK(CMP_ENABLE[2], 1'b1)
    `CHK(REF_EXTERNAL, 1'b0)
    // A reset in mid-run clears every register and output.
    RST_N <= 1'b0;
    step(2);
    RST_N <= 1'b1;
    step(1);
    `CHK({CMP_ENABLE, RESULT_OE, RESULT_PIN, IRQ}, 10'h000)
    rchk(8'h0C, 32'h0000_0000);
    rchk(`TCC_ADR_IMASK, 32'h0000_0000);
    results();
  end
endmodule : tcc_top_tb
